/* hw/lscl_column_loader.sv */
// Column loader: enable chain, data register, line latch and level select
`timescale 1ns/1ps
`include "lscl_regs.svh"

module lscl_column_loader
    import lscl_pkg::*;
#(
    parameter int SEG_COUNT = `LSCL_SEG_COUNT,
    parameter int NIB_COUNT = `LSCL_NIB_COUNT
) (
    input  wire logic                     clock_i,
    input  wire logic                     nrst_i,
    input  wire logic                     pixel_shift_strobe_i,
    input  wire logic                     line_latch_pulse_i,
    input  wire logic [`LSCL_NIB_WIDTH-1:0] display_nibble_i,
    input  wire logic                     shift_direction_select_i,
    input  wire logic                     frame_alternation_i,
    input  wire logic                     forced_blank_n_i,
    input  wire logic                     chain_enable_port_a_i,
    output logic                          chain_enable_port_a_o,
    output logic                          chain_enable_port_a_oe_o,
    input  wire logic                     chain_enable_port_b_i,
    output logic                          chain_enable_port_b_o,
    output logic                          chain_enable_port_b_oe_o,
    output lscl_level_t                   segment_outputs_o [SEG_COUNT]
);
    // Edge detector state
    logic                       strobe_d_r,  strobe_d_nxt;
    logic                       latch_d_r,   latch_d_nxt;

    // Enable chain state
    logic [NIB_COUNT-1:0]       ena_sr_r,    ena_sr_nxt;
    logic                       full_r,      full_nxt;

    // Data register and output latch state
    logic [SEG_COUNT-1:0]       data_reg_r,  data_reg_nxt;
    logic [SEG_COUNT-1:0]       out_latch_r, out_latch_nxt;

    // Decoded strobes and gated internal bus
    logic                       chain_in;
    logic                       chain_active;
    logic                       strobe_fall;
    logic                       latch_fall;
    logic                       int_strobe;
    logic [`LSCL_NIB_WIDTH-1:0] int_bus;
    logic [`LSCL_NIB_WIDTH-1:0] ordered_bus;
    logic [NIB_COUNT-1:0]       slot_load;

    // Token of the first slot filled in a line
    function automatic logic [NIB_COUNT-1:0] first_token(input logic fwd);
        logic [NIB_COUNT-1:0] tok;
        tok = '0;
        if (fwd) begin
            tok[0] = 1'b1;
        end else begin
            tok[NIB_COUNT-1] = 1'b1;
        end
        return tok;
    endfunction : first_token

    // Token after one accepted nibble
    function automatic logic [NIB_COUNT-1:0] step_token(
        input logic                 fwd,
        input logic [NIB_COUNT-1:0] tok
    );
        logic [NIB_COUNT-1:0] nxt;
        if (tok == '0) begin
            nxt = first_token(fwd);
        end else if (fwd) begin
            nxt = tok << 1;
        end else begin
            nxt = tok >> 1;
        end
        return nxt;
    endfunction : step_token

    // Token sits on the last slot of the fill order
    function automatic logic last_token(
        input logic                 fwd,
        input logic [NIB_COUNT-1:0] tok
    );
        logic hit;
        hit = fwd ? tok[NIB_COUNT-1] : tok[0];
        return hit;
    endfunction : last_token

    // Lowest nibble bit goes to the first segment in fill order
    function automatic logic [`LSCL_NIB_WIDTH-1:0] order_nibble(
        input logic                       fwd,
        input logic [`LSCL_NIB_WIDTH-1:0] nib
    );
        logic [`LSCL_NIB_WIDTH-1:0] res;
        res = nib;
        if (!fwd) begin
            for (int b = 0; b < `LSCL_NIB_WIDTH; b++) begin
                res[b] = nib[`LSCL_NIB_WIDTH-1-b];
            end
        end
        return res;
    endfunction : order_nibble

    // Direction select high: port a is input, port b output; low: reversed
    assign chain_in                 = shift_direction_select_i ? chain_enable_port_a_i
                                                               : chain_enable_port_b_i;
    assign chain_enable_port_a_oe_o = !shift_direction_select_i;
    assign chain_enable_port_b_oe_o = shift_direction_select_i;
    assign chain_enable_port_a_o    = full_r;
    assign chain_enable_port_b_o    = full_r;

    assign strobe_fall = strobe_d_r && !pixel_shift_strobe_i;
    assign latch_fall  = latch_d_r && !line_latch_pulse_i;

    // Full line blocks further strobes until the next latch pulse
    assign chain_active = chain_in && !full_r;

    // Gated strobe and bus stay low when not enabled to save power
    assign int_strobe  = strobe_fall && chain_active && !line_latch_pulse_i;
    assign int_bus     = int_strobe ? display_nibble_i : '0;
    assign ordered_bus = order_nibble(shift_direction_select_i, int_bus);
    assign slot_load   = int_strobe ? ena_sr_nxt : '0;

    // Edge detectors on the sampled strobe and latch levels
    always_comb begin
        strobe_d_nxt = pixel_shift_strobe_i;
        latch_d_nxt  = line_latch_pulse_i;
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            strobe_d_r <= 1'b0;
            latch_d_r  <= 1'b0;
        end else begin
            strobe_d_r <= strobe_d_nxt;
            latch_d_r  <= latch_d_nxt;
        end
    end

    // Enable token and line full flag
    always_comb begin
        ena_sr_nxt = ena_sr_r;
        full_nxt   = full_r;
        if (line_latch_pulse_i) begin
            ena_sr_nxt = '0;
            full_nxt   = 1'b0;
        end else if (int_strobe) begin
            ena_sr_nxt = step_token(shift_direction_select_i, ena_sr_r);
            if (last_token(shift_direction_select_i, ena_sr_nxt)) begin
                full_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            ena_sr_r <= '0;
            full_r   <= 1'b0;
        end else begin
            ena_sr_r <= ena_sr_nxt;
            full_r   <= full_nxt;
        end
    end

    // Data register: the token slot takes the nibble
    always_comb begin
        data_reg_nxt = data_reg_r;
        for (int i = 0; i < NIB_COUNT; i++) begin
            if (slot_load[i]) begin
                data_reg_nxt[i*`LSCL_NIB_WIDTH +: `LSCL_NIB_WIDTH] = ordered_bus;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            data_reg_r <= '0;
        end else begin
            data_reg_r <= data_reg_nxt;
        end
    end

    // Output latch follows the data register on the latch falling edge
    always_comb begin
        out_latch_nxt = out_latch_r;
        if (latch_fall) begin
            out_latch_nxt = data_reg_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            out_latch_r <= '0;
        end else begin
            out_latch_r <= out_latch_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < SEG_COUNT; g++) begin : g_seg
            lscl_level_sel u_sel (
                .data_i              (out_latch_r[g]),
                .frame_alternation_i (frame_alternation_i),
                .forced_blank_n_i    (forced_blank_n_i),
                .level_o             (segment_outputs_o[g])
            );
        end
    endgenerate
endmodule : lscl_column_loader

/* hw/lscl_regs.svh */
// Constants of the LCD segment column loader
`ifndef LSCL_REGS_SVH
`define LSCL_REGS_SVH
`define LSCL_SEG_COUNT    80
`define LSCL_NIB_WIDTH    4
`define LSCL_NIB_COUNT    20
`define LSCL_LVL_WIDTH    2
`endif

/* hw/lscl_pkg.sv */
// Types of the LCD segment column loader
package lscl_pkg;
    typedef enum logic [1:0] {
        LSCL_LVL_TOP,
        LSCL_LVL_UPPER_MID,
        LSCL_LVL_LOWER_MID,
        LSCL_LVL_BOTTOM
    } lscl_level_t;
endpackage : lscl_pkg

/* hw/lscl_level_sel.sv */
// Drive level selection for one segment output
`timescale 1ns/1ps
module lscl_level_sel
    import lscl_pkg::*;
(
    input  wire logic        data_i,
    input  wire logic        frame_alternation_i,
    input  wire logic        forced_blank_n_i,
    output lscl_level_t      level_o
);
    always_comb begin
        if (!forced_blank_n_i) begin
            level_o = LSCL_LVL_TOP;
        end else if (data_i) begin
            level_o = frame_alternation_i ? LSCL_LVL_TOP : LSCL_LVL_BOTTOM;
        end else begin
            level_o = frame_alternation_i ? LSCL_LVL_UPPER_MID : LSCL_LVL_LOWER_MID;
        end
    end
endmodule : lscl_level_sel

/* bench/lscl_monitor.sv */
// Port assertions for the column loader
`timescale 1ns/1ps
module lscl_monitor
    import lscl_pkg::*;
#(parameter int SEG_COUNT = 80) (
    input logic        clock_i,
    input logic        nrst_i,
    input logic        line_latch_pulse_i,
    input logic        shift_direction_select_i,
    input logic        frame_alternation_i,
    input logic        forced_blank_n_i,
    input logic        chain_enable_port_a_o,
    input logic        chain_enable_port_a_oe_o,
    input logic        chain_enable_port_b_oe_o,
    input lscl_level_t segment_outputs_o [SEG_COUNT]
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    property p_blank; !forced_blank_n_i |-> segment_outputs_o[1] == LSCL_LVL_TOP; endproperty
    a_blank: assert property (p_blank) else $error("blank");
    property p_dir; $stable(shift_direction_select_i) |-> chain_enable_port_b_oe_o ==
        shift_direction_select_i && chain_enable_port_a_oe_o != shift_direction_select_i; endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_clear; line_latch_pulse_i |=> !chain_enable_port_a_o; endproperty
    a_clear: assert property (p_clear) else $error("clear");
    property p_hold; chain_enable_port_a_o && !line_latch_pulse_i |=> chain_enable_port_a_o; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rise; $rose(chain_enable_port_a_o) |-> !$past(line_latch_pulse_i); endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_latch; $changed(segment_outputs_o[0]) && $stable(frame_alternation_i) &&
        $stable(forced_blank_n_i) |-> $past(line_latch_pulse_i, 2) && !$past(line_latch_pulse_i); endproperty
    a_latch: assert property (p_latch) else $error("latch");
    property p_alt_first; forced_blank_n_i |-> segment_outputs_o[0][1] != frame_alternation_i;
    endproperty
    a_alt_first: assert property (p_alt_first) else $error("alternation");
    property p_alt_last; forced_blank_n_i |-> segment_outputs_o[79][1] != frame_alternation_i;
    endproperty
    a_alt_last: assert property (p_alt_last) else $error("alternation");
endmodule : lscl_monitor
bind lscl_column_loader lscl_monitor #(.SEG_COUNT(SEG_COUNT)) lscl_monitor_inst (.clock_i,
    .nrst_i, .line_latch_pulse_i, .shift_direction_select_i, .frame_alternation_i,
    .forced_blank_n_i, .chain_enable_port_a_o, .chain_enable_port_a_oe_o,
    .chain_enable_port_b_oe_o, .segment_outputs_o);

/* bench/lscl_ctrl_model.sv */
// Controller model feeding nibbles and latch pulses
`timescale 1ns/1ps
module lscl_ctrl_model (
    input  logic       clock_i,
    output logic       strobe_o = 1'b0,
    output logic       latch_o = 1'b0,
    output logic [3:0] nibble_o = 4'h0
);
    task automatic send_line(input int first, input int n, input logic [3:0] off);
        for (int k = first; k < first + n; k++) begin
            @(posedge clock_i) #1 strobe_o = 1'b1;
            nibble_o = 4'(k) ^ off;
            @(posedge clock_i) #1 strobe_o = 1'b0;
            @(posedge clock_i) #1 nibble_o = ~nibble_o;
        end
    endtask : send_line
    task automatic pulse_latch();
        @(posedge clock_i) #1 latch_o = 1'b1;
        @(posedge clock_i) #1 latch_o = 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask : pulse_latch
endmodule : lscl_ctrl_model

/* bench/lscl_column_loader_bench.sv */
// Self-checking bench of the column loader
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; $display("FAIL %0t value", $time); end end
module lscl_column_loader_bench
    import lscl_pkg::*;
;
    logic clock_i, nrst_i, pixel_shift_strobe_i, line_latch_pulse_i, enable_in;
    logic shift_direction_select_i, frame_alternation_i, forced_blank_n_i;
    logic chain_enable_port_a_i, chain_enable_port_a_o, chain_enable_port_a_oe_o;
    logic chain_enable_port_b_i, chain_enable_port_b_o, chain_enable_port_b_oe_o;
    logic [3:0] display_nibble_i;
    lscl_level_t segment_outputs_o [80];
    int err_total, samples_checked, cycles;
    assign chain_enable_port_a_i = chain_enable_port_a_oe_o ? chain_enable_port_a_o : enable_in;
    assign chain_enable_port_b_i = chain_enable_port_b_oe_o ? chain_enable_port_b_o : enable_in;
    lscl_column_loader lscl_column_loader_inst (.clock_i, .nrst_i, .pixel_shift_strobe_i,
        .line_latch_pulse_i, .display_nibble_i, .shift_direction_select_i,
        .frame_alternation_i, .forced_blank_n_i, .chain_enable_port_a_i,
        .chain_enable_port_a_o, .chain_enable_port_a_oe_o, .chain_enable_port_b_i,
        .chain_enable_port_b_o, .chain_enable_port_b_oe_o, .segment_outputs_o);
    lscl_ctrl_model lscl_ctrl_model_inst (.clock_i, .strobe_o(pixel_shift_strobe_i),
        .latch_o(line_latch_pulse_i), .nibble_o(display_nibble_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check_line(input logic [3:0] off);
        int t;
        logic [3:0] v;
        lscl_level_t e;
        for (int s = 0; s < 80; s++) begin
            t = shift_direction_select_i ? s : 79 - s;
            v = 4'(t / 4) ^ off;
            e = frame_alternation_i ? (v[t % 4] ? LSCL_LVL_TOP : LSCL_LVL_UPPER_MID)
                : (v[t % 4] ? LSCL_LVL_BOTTOM : LSCL_LVL_LOWER_MID);
            `CHK(segment_outputs_o[s], forced_blank_n_i ? e : LSCL_LVL_TOP)
        end
    endtask : check_line
    task automatic t_fill(input logic sel, input logic [3:0] off);
        shift_direction_select_i = sel;
        lscl_ctrl_model_inst.send_line(0, 19, off);
        `CHK(sel ? chain_enable_port_b_o : chain_enable_port_a_o, 1'b0)
        lscl_ctrl_model_inst.send_line(19, 1, off);
        `CHK(sel ? chain_enable_port_b_o : chain_enable_port_a_o, 1'b1)
        `CHK(chain_enable_port_b_oe_o, sel)
        lscl_ctrl_model_inst.send_line(0, 1, ~off);
        lscl_ctrl_model_inst.pulse_latch();
        `CHK(chain_enable_port_a_o, 1'b0)
        check_line(off);
    endtask : t_fill
    task automatic t_off(input logic [3:0] prev, input logic [3:0] off);
        enable_in = 1'b0;
        lscl_ctrl_model_inst.send_line(0, 20, off);
        `CHK(chain_enable_port_a_o, 1'b0)
        lscl_ctrl_model_inst.pulse_latch();
        check_line(prev);
        enable_in = 1'b1;
    endtask : t_off
    task automatic t_blank(input logic [3:0] off);
        frame_alternation_i = 1'b0;
        @(posedge clock_i) #1 check_line(off);
        forced_blank_n_i = 1'b0;
        @(posedge clock_i) #1 check_line(off);
        forced_blank_n_i = 1'b1;
        frame_alternation_i = 1'b1;
        @(posedge clock_i) #1 check_line(off);
    endtask : t_blank
    initial begin
        nrst_i = 1'b0;
        shift_direction_select_i = 1'b1;
        frame_alternation_i = 1'b1;
        forced_blank_n_i = 1'b1;
        enable_in = 1'b1;
        repeat (20) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        t_fill(1'b1, 4'h5);
        t_fill(1'b0, 4'ha);
        t_off(4'ha, 4'h3);
        t_blank(4'ha);
        print_verdict();
    end
endmodule : lscl_column_loader_bench
